// ### pkg/csrm_pkg.sv
// constants and types of the clock, sleep and reset manager
// Operation
// - idle sleep halts cpu clock only; memory, timers, serial port, interrupts run
// - deepest sleep stops main oscillator and all domains; wake by interrupt or reset
// - power-save sleep keeps the asynchronous timer running, all else asleep
// - noise-reduction sleep stops cpu and i/o except asynchronous timer and converter
// - standby sleep keeps the crystal oscillator running, rest asleep
// - extended standby keeps main oscillator and asynchronous timer running
// - main clock source decoded from the 4-bit clock source fuse field ranges
// - fuse bit one is unprogrammed, zero is programmed
// - internal rc option runs from on-chip oscillator, nominal 1 MHz
// - reset pin low longer than 500 ns generates reset; the partner leaves the low width to its caller, which also issues too-short lows
// - during reset all general-purpose port pins are high impedance
// - with debug port enabled, pull-ups on its three input pins stay on in reset; srst_in clears the enable bit, so only pin reset keeps them on
// - asynchronous timer oscillator suits a watch crystal, no external capacitors
package csrm_pkg;
    // register port map
    localparam logic [3:0] CSRM_ADDR_SLEEP_CTRL = 4'h0;
    localparam logic [3:0] CSRM_ADDR_STATUS = 4'h1;
    localparam logic [3:0] CSRM_ADDR_WAKE = 4'h2;
    // sleep control fields
    localparam int CSRM_MODE_LSB = 0;
    localparam int CSRM_MODE_W = 3;
    localparam int CSRM_DBG_EN_BIT = 3;
    localparam logic [7:0] CSRM_SLEEP_CTRL_RST = 8'h00;
    // status fields
    localparam int CSRM_ST_SRC_LSB = 0;
    localparam int CSRM_ST_ASLEEP_BIT = 3;
    localparam int CSRM_ST_RESET_BIT = 4;
    // timing
    localparam int CSRM_CLK_PERIOD_NS = 10;
    localparam int CSRM_RESET_MIN_NS = 500;
    localparam int CSRM_RESET_MIN_CYC = (CSRM_RESET_MIN_NS + CSRM_CLK_PERIOD_NS - 1) / CSRM_CLK_PERIOD_NS;
    localparam int CSRM_INT_RC_KHZ = 1000;
    localparam int CSRM_ATIMER_HZ_X1000 = 32768000;
    localparam int CSRM_INT_RC_DIV = (1000000 / CSRM_INT_RC_KHZ) / CSRM_CLK_PERIOD_NS / 2;

    typedef enum logic [2:0] {
        CSRM_SLP_IDLE,
        CSRM_SLP_NOISE_RED,
        CSRM_SLP_POWER_DOWN,
        CSRM_SLP_POWER_SAVE,
        CSRM_SLP_RSVD4,
        CSRM_SLP_RSVD5,
        CSRM_SLP_STANDBY,
        CSRM_SLP_EXT_STANDBY
    } csrm_sleep_mode_type;

    typedef enum logic [2:0] {
        CSRM_SRC_CRYSTAL,
        CSRM_SRC_LF_CRYSTAL,
        CSRM_SRC_EXT_RC,
        CSRM_SRC_INT_RC,
        CSRM_SRC_EXT_CLK
    } csrm_clk_src_type;

    typedef enum {
        CSRM_ST_RUN,
        CSRM_ST_SLEEP
    } csrm_state_type;
endpackage

// ### rtl/csrm_clock_sleep_reset_manager.sv
// clock source select, sleep gating and reset pin handling
`timescale 1ns/1ns
module csrm_clock_sleep_reset_manager
    import csrm_pkg::*;
#(
    parameter int PORT_W = 32,
    parameter int RESET_MIN_CYC = CSRM_RESET_MIN_CYC,
    parameter int RC_DIV = CSRM_INT_RC_DIV
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // fuse and pins
    input wire logic [3:0] clock_source_fuse_field_in,
    input wire logic reset_pin_n_in,
    input wire logic sleep_req_in,
    input wire logic wake_irq_in,
    // port pin drive from the port logic
    input wire logic [PORT_W-1:0] port_oe_req_in,
    output logic [PORT_W-1:0] port_oe_out,
    output logic [2:0] debug_pullup_en_out,
    // domain clock enables
    output logic cpu_clk_en_out,
    output logic mem_clk_en_out,
    output logic io_clk_en_out,
    output logic adc_clk_en_out,
    output logic atimer_clk_en_out,
    output logic main_osc_en_out,
    output logic int_rc_en_out,
    output logic int_rc_clk_out,
    output logic [2:0] clock_source_select_out,
    output logic core_reset_out
);
    csrm_state_type state, next_state;
    logic [7:0] sleep_ctrl, next_sleep_ctrl;
    logic [7:0] rdata, next_rdata;
    logic [$clog2(RESET_MIN_CYC+1)-1:0] low_cnt, next_low_cnt, chk_run, next_chk_run;
    logic pin_reset, next_pin_reset;
    logic [$clog2(RC_DIV+1)-1:0] rc_cnt, next_rc_cnt;
    logic rc_clk, next_rc_clk;
    logic [2:0] src;
    csrm_sleep_mode_type mode;
    logic asleep;
    logic in_reset;

    // fuse decode; a zero bit means programmed, so all ones is the crystal default
    always_comb begin
        unique casez (clock_source_fuse_field_in)
            4'b1111, 4'b1110, 4'b1101, 4'b1100, 4'b1011, 4'b1010: src = CSRM_SRC_CRYSTAL;
            4'b1001, 4'b1000: src = CSRM_SRC_LF_CRYSTAL;
            4'b0111, 4'b0110, 4'b0101: src = CSRM_SRC_EXT_RC;
            4'b0100, 4'b0011, 4'b0010: src = CSRM_SRC_INT_RC;
            default: src = CSRM_SRC_EXT_CLK;
        endcase
    end

    assign mode = csrm_sleep_mode_type'(sleep_ctrl[CSRM_MODE_LSB +: CSRM_MODE_W]);
    assign asleep = (state == CSRM_ST_SLEEP);
    assign in_reset = pin_reset || !reset_pin_n_in;

    // reset pin: a low shorter than the minimum may be ignored, longer always resets
    always_comb begin
        next_low_cnt = low_cnt;
        next_pin_reset = 1'b0;
        next_chk_run = reset_pin_n_in ? '0 : (chk_run == RESET_MIN_CYC[$bits(chk_run)-1:0]) ? chk_run : chk_run + 1'b1;
        if (reset_pin_n_in) begin
            next_low_cnt = '0;
        end else if (low_cnt < RESET_MIN_CYC[$bits(low_cnt)-1:0]) begin
            next_low_cnt = low_cnt + 1'b1;
        end else begin
            next_pin_reset = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            low_cnt <= '0;
            chk_run <= '0;
            pin_reset <= 1'b0;
        end else begin
            low_cnt <= next_low_cnt;
            chk_run <= next_chk_run;
            pin_reset <= next_pin_reset;
        end
    end

    // sleep state machine and registers
    always_comb begin
        next_state = state;
        next_sleep_ctrl = sleep_ctrl;
        next_rdata = 8'h00;
        if (reg_wr_in && reg_addr_in == CSRM_ADDR_SLEEP_CTRL) begin
            next_sleep_ctrl = reg_wdata_in;
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                CSRM_ADDR_SLEEP_CTRL: next_rdata = sleep_ctrl;
                CSRM_ADDR_STATUS: next_rdata = {3'h0, in_reset, asleep, src};
                default: next_rdata = 8'h00;
            endcase
        end
        case (state)
            CSRM_ST_RUN: begin
                if (sleep_req_in) begin
                    next_state = CSRM_ST_SLEEP;
                end
            end
            CSRM_ST_SLEEP: begin
                // only an interrupt, a write to the wake register or a reset ends sleep
                if (wake_irq_in || (reg_wr_in && reg_addr_in == CSRM_ADDR_WAKE)) begin
                    next_state = CSRM_ST_RUN;
                end
            end
            default: next_state = CSRM_ST_RUN;
        endcase
        if (pin_reset) begin
            next_state = CSRM_ST_RUN;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state <= CSRM_ST_RUN;
            sleep_ctrl <= CSRM_SLEEP_CTRL_RST;
            rdata <= 8'h00;
        end else begin
            state <= next_state;
            sleep_ctrl <= next_sleep_ctrl;
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_out = rdata;

    // domain gating per sleep mode; register contents are kept because flops are not reset
    always_comb begin
        cpu_clk_en_out = 1'b1;
        mem_clk_en_out = 1'b1;
        io_clk_en_out = 1'b1;
        adc_clk_en_out = 1'b1;
        atimer_clk_en_out = 1'b1;
        main_osc_en_out = 1'b1;
        if (asleep) begin
            cpu_clk_en_out = 1'b0;
            case (mode)
                CSRM_SLP_IDLE: cpu_clk_en_out = 1'b0;
                CSRM_SLP_NOISE_RED: begin
                    mem_clk_en_out = 1'b0;
                    io_clk_en_out = 1'b0;
                end
                CSRM_SLP_POWER_SAVE: begin
                    mem_clk_en_out = 1'b0;
                    io_clk_en_out = 1'b0;
                    adc_clk_en_out = 1'b0;
                    main_osc_en_out = 1'b0;
                end
                CSRM_SLP_STANDBY: begin
                    mem_clk_en_out = 1'b0;
                    io_clk_en_out = 1'b0;
                    adc_clk_en_out = 1'b0;
                    atimer_clk_en_out = 1'b0;
                end
                CSRM_SLP_EXT_STANDBY: begin
                    mem_clk_en_out = 1'b0;
                    io_clk_en_out = 1'b0;
                    adc_clk_en_out = 1'b0;
                end
                default: begin
                    // power-down and reserved codes stop everything
                    mem_clk_en_out = 1'b0;
                    io_clk_en_out = 1'b0;
                    adc_clk_en_out = 1'b0;
                    atimer_clk_en_out = 1'b0;
                    main_osc_en_out = 1'b0;
                end
            endcase
        end
    end

    // internal rc: a divided stand-in for the 1 MHz on-chip oscillator
    always_comb begin
        next_rc_cnt = rc_cnt;
        next_rc_clk = rc_clk;
        if (src != CSRM_SRC_INT_RC || !main_osc_en_out) begin
            next_rc_cnt = '0;
            next_rc_clk = 1'b0;
        end else if (rc_cnt == RC_DIV[$bits(rc_cnt)-1:0] - 1'b1) begin
            next_rc_cnt = '0;
            next_rc_clk = !rc_clk;
        end else begin
            next_rc_cnt = rc_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rc_cnt <= '0;
            rc_clk <= 1'b0;
        end else begin
            rc_cnt <= next_rc_cnt;
            rc_clk <= next_rc_clk;
        end
    end

    assign int_rc_en_out = (src == CSRM_SRC_INT_RC) && main_osc_en_out;
    assign int_rc_clk_out = rc_clk;
    assign clock_source_select_out = src;
    // the watch crystal pins need no drive here; timer oscillator is always analog
    assign core_reset_out = srst_in || in_reset;
    // pins float as soon as the pin goes low, before the filter; no clock needed
    assign port_oe_out = (srst_in || in_reset) ? '0 : port_oe_req_in;
    assign debug_pullup_en_out = {3{sleep_ctrl[CSRM_DBG_EN_BIT]}};

    // checks
    property p_reset_min;
        @(posedge clk_sys_in) disable iff (srst_in)
        (!reset_pin_n_in && chk_run == RESET_MIN_CYC[$bits(chk_run)-1:0]) |=> pin_reset;
    endproperty
    a_reset_min: assert property (p_reset_min) else $error("long reset low did not reset");

    property p_tristate;
        @(posedge clk_sys_in) !reset_pin_n_in |-> port_oe_out == '0;
    endproperty
    a_tristate: assert property (p_tristate) else $error("port driven during reset");

    property p_idle;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_IDLE) |-> !cpu_clk_en_out && mem_clk_en_out && io_clk_en_out;
    endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong");

    property p_pdown;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_POWER_DOWN) |-> !main_osc_en_out && !atimer_clk_en_out;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down left a clock on");

    property p_psave;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_POWER_SAVE) |-> atimer_clk_en_out && !io_clk_en_out;
    endproperty
    a_psave: assert property (p_psave) else $error("power-save gating wrong");

    property p_noise;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_NOISE_RED) |-> adc_clk_en_out && atimer_clk_en_out && !io_clk_en_out;
    endproperty
    a_noise: assert property (p_noise) else $error("noise reduction gating wrong");

    property p_standby;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_STANDBY) |-> main_osc_en_out && !cpu_clk_en_out;
    endproperty
    a_standby: assert property (p_standby) else $error("standby oscillator off");

    property p_ext_standby;
        @(posedge clk_sys_in) disable iff (srst_in)
        (asleep && mode == CSRM_SLP_EXT_STANDBY) |-> main_osc_en_out && atimer_clk_en_out;
    endproperty
    a_ext_standby: assert property (p_ext_standby) else $error("extended standby gating wrong");

    property p_fuse;
        @(posedge clk_sys_in) (clock_source_fuse_field_in inside {4'h2, 4'h3, 4'h4}) |-> src == CSRM_SRC_INT_RC;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse decode wrong");

    property p_sleep_entry;
        @(posedge clk_sys_in) disable iff (srst_in || pin_reset)
        (!asleep && !sleep_req_in) |=> !asleep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without request");
endmodule

// ### testbench/csrm_ext_source_model.sv
// model of the fuse bank and the external reset source
`timescale 1ns/1ns
module csrm_ext_source_model (
    // clock
    input wire logic clk_sys_in,
    // pins toward the manager
    output logic [3:0] clock_source_fuse_field_out,
    output logic reset_pin_n_out
);
    initial begin
        clock_source_fuse_field_out = 4'hf; // erased fuses read as all ones
        reset_pin_n_out = 1'b1;
    end
    task automatic set_fuse(input logic [3:0] val);
        @(posedge clk_sys_in);
        clock_source_fuse_field_out <= val; // one means unprogrammed
    endtask
    // the caller decides the width, so that too-short pulses can be issued on purpose
    task automatic pin_low();
        @(posedge clk_sys_in);
        reset_pin_n_out <= 1'b0; // driven low here; the caller sets how long it stays low
    endtask
    task automatic pin_high();
        @(posedge clk_sys_in);
        reset_pin_n_out <= 1'b1;
    endtask
endmodule

// ### testbench/testbench.sv
// register-call tests of the clock, sleep and reset manager
`timescale 1ns/1ns
module testbench;
    import csrm_pkg::*;
    localparam int RST_MIN = 4;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sleep_req_in = 1'b0;
    logic wake_irq_in = 1'b0;
    logic [31:0] port_oe_req_in = 32'hffffffff;
    logic [7:0] reg_rdata_out;
    logic [3:0] fuse;
    logic pin_n;
    logic [31:0] port_oe_out;
    logic [2:0] debug_pullup_en_out, clock_source_select_out;
    logic cpu_en, mem_en, io_en, adc_en, at_en, osc_en, int_rc_en_out, int_rc_clk_out, core_reset_out;
    logic [5:0] en;
    logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
    logic [5:0] exp_en [8] = '{6'h1f, 6'h06, 6'h00, 6'h02, 6'h01, 6'h03, 6'h00, 6'h00};
    logic [5:0] mask [8] = '{6'h3f, 6'h2e, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f};
    int fails = 0;
    int check_count = 0;
    int cnt;
    logic prev;
    assign en = {cpu_en, mem_en, io_en, adc_en, at_en, osc_en};
    always #5 clk_sys_in = ~clk_sys_in;

    csrm_ext_source_model u_ext (.clk_sys_in(clk_sys_in), .clock_source_fuse_field_out(fuse),
        .reset_pin_n_out(pin_n));
    csrm_clock_sleep_reset_manager #(.PORT_W(32), .RESET_MIN_CYC(RST_MIN), .RC_DIV(4)) u_dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .clock_source_fuse_field_in(fuse), .reset_pin_n_in(pin_n), .sleep_req_in(sleep_req_in),
        .wake_irq_in(wake_irq_in), .port_oe_req_in(port_oe_req_in), .port_oe_out(port_oe_out),
        .debug_pullup_en_out(debug_pullup_en_out), .cpu_clk_en_out(cpu_en), .mem_clk_en_out(mem_en),
        .io_clk_en_out(io_en), .adc_clk_en_out(adc_en), .atimer_clk_en_out(at_en), .main_osc_en_out(osc_en),
        .int_rc_en_out(int_rc_en_out), .int_rc_clk_out(int_rc_clk_out),
        .clock_source_select_out(clock_source_select_out), .core_reset_out(core_reset_out));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        chk("rdata", exp, reg_rdata_out);
    endtask
    // one-cycle pulse on sleep or wake; gating is settled by the following negedge
    task automatic pulse(input logic is_wake);
        @(posedge clk_sys_in);
        if (is_wake) wake_irq_in <= 1'b1;
        else sleep_req_in <= 1'b1;
        @(posedge clk_sys_in);
        wake_irq_in <= 1'b0;
        sleep_req_in <= 1'b0;
        @(negedge clk_sys_in);
    endtask
    function automatic logic [2:0] exp_src(input logic [3:0] f);
        if (f >= 4'ha) return 3'h0;
        if (f >= 4'h8) return 3'h1;
        if (f >= 4'h5) return 3'h2;
        if (f >= 4'h2) return 3'h3;
        return 3'h4;
    endfunction
    task automatic end_of_test();
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        end_of_test();
    end

    initial begin
        @(negedge clk_sys_in);
        chk("oe_in_srst", 32'h0, port_oe_out);
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rd(CSRM_ADDR_SLEEP_CTRL, CSRM_SLEEP_CTRL_RST);
        chk("en_reset", 6'h3f, en);
        for (int f = 0; f < 16; f++) begin
            u_ext.set_fuse(f[3:0]);
            @(negedge clk_sys_in);
            chk("src_sel", exp_src(f[3:0]), clock_source_select_out);
            rd(CSRM_ADDR_STATUS, {5'h0, exp_src(f[3:0])});
        end
        // sampled at falling edges; forty cycles hold exactly ten half periods of the divide-by-eight stand-in
        u_ext.set_fuse(4'h3);
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        cnt = 0;
        prev = int_rc_clk_out;
        repeat (40) begin
            @(negedge clk_sys_in);
            if (int_rc_clk_out !== prev) cnt++;
            prev = int_rc_clk_out;
        end
        chk("rc_toggles", 10, cnt);
        chk("rc_en", 1, int_rc_en_out);
        u_ext.set_fuse(4'hf);
        @(negedge clk_sys_in);
        chk("rc_en_off", 0, int_rc_en_out);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(CSRM_ADDR_SLEEP_CTRL, {5'h0, modes[i]});
            @(negedge clk_sys_in);
            chk("en_no_req", 6'h3f, en);
            pulse(1'b0);
            chk("en_sleep", exp_en[i] & mask[i], en & mask[i]);
            rd(CSRM_ADDR_STATUS, 8'h08);
            if (i[0]) pulse(1'b1);
            else wr(CSRM_ADDR_WAKE, 8'h00);
            @(negedge clk_sys_in);
            chk("en_wake", 6'h3f, en);
        end
        wr(CSRM_ADDR_SLEEP_CTRL, 8'h0a);
        port_oe_req_in <= 32'ha5a50f0f;
        @(negedge clk_sys_in);
        chk("oe_pass", 32'ha5a50f0f, port_oe_out);
        chk("pullup", 3'h7, debug_pullup_en_out);
        u_ext.pin_low();
        repeat (RST_MIN - 2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("oe_short", 32'h0, port_oe_out);
        u_ext.pin_high();
        repeat (3) @(posedge clk_sys_in);
        rd(CSRM_ADDR_SLEEP_CTRL, 8'h0a);
        rd(CSRM_ADDR_STATUS, 8'h00);
        pulse(1'b0);
        chk("en_pd", 6'h00, en);
        u_ext.pin_low();
        repeat (RST_MIN + 3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("core_rst", 1, core_reset_out);
        chk("oe_long", 32'h0, port_oe_out);
        chk("pullup_rst", 3'h7, debug_pullup_en_out);
        u_ext.pin_high();
        for (int w = 0; w < 20 && core_reset_out !== 1'b0; w++) @(negedge clk_sys_in);
        chk("core_rst_end", 0, core_reset_out);
        chk("en_after_rst", 6'h3f, en);
        end_of_test();
    end
endmodule
